// ===== src/otl_overtravel.sv
// overtravel limit control with an AXI4-Lite register slave
// assumes limit, mode and motion inputs are synchronous to aclk
//
// What this block does
// RL1 - forward limit input off blocks forward motion and flags forward overtravel
// RL2 - reverse limit input off blocks reverse motion and flags reverse overtravel
// RL3 - motion away from a tripped limit stays allowed during overtravel
// RL4 - position error is held after an overtravel stop until host clears it
// RL5 - forward limit setting 2 uses the input, 8 ignores it; restart applies
// RL6 - reverse limit setting 3 uses the input, 8 ignores it; restart applies
// RL7 - a limit tripping while running applies the restart-latched stop method
// RL8 - stop codes: brake, brake then coast, coast, decel+clamp, decel+coast
// RL9 - force control never decelerates; brake or coast, then coasting
// RL10 - zero clamp holds position against a zero position reference
// RL11 - emergency stop force 0 to 800 percent, default 800, applies at once; register takes any 10-bit value up to 1023
// RL12 - applied stop force is clamped to the motor maximum force
// RL13 - enabled warning raised when a limit trips with power on, even briefly
// RL14 - warning setting digit four: 0 disables, 1 enables, applies at once
// RL15 - with a reference active, warn only for a limit in its direction
// RL16 - with no reference active, warn for either limit
// RL17 - no warning while motor power is off
// RL18 - power turning on over a tripped limit raises no warning
// RL19 - warning held one second after overtravel ends, then cleared
// RL20 - warning is informational and does not change stopping or commands
// RL21 - forward, reverse and warning flags readable by host and software
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module otl_overtravel import otl_pkg::*; #(
  parameter int HOLD_CYC = int'(OTL_HOLD_CYC)
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic fwd_limit_in,
  input wire logic rev_limit_in,
  input wire logic error_clear_in,
  input wire logic motor_power_in,
  input wire logic pos_mode_in,
  input wire logic force_mode_in,
  input wire logic ref_active_in,
  input wire logic ref_fwd_in,
  input wire logic motor_moving_in,
  input wire logic motor_stopped_in,
  input wire logic [9:0] max_force_in,
  output logic fwd_allow_out,
  output logic rev_allow_out,
  output logic fwd_ot_out,
  output logic rev_ot_out,
  output logic dynamic_brake_out,
  output logic coast_out,
  output logic decel_out,
  output logic zero_clamp_out,
  output logic [9:0] stop_force_out,
  output logic hold_error_out,
  output logic warning_out
);

  typedef struct packed {
    logic aw_rdy;
    logic w_rdy;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] fwd_cfg;
    logic [3:0] rev_cfg;
    logic [7:0] stop_cfg;
    logic [3:0] fwd_act;
    logic [3:0] rev_act;
    logic [7:0] stop_act;
    logic [9:0] estop;
    logic [15:0] warn_cfg;
    logic fwd_ot;
    logic rev_ot;
    logic pwr_prev;
    otl_state_t st;
    logic err_hold;
    logic warn;
    logic [25:0] warn_cnt;
    logic fwd_allow;
    logic rev_allow;
    logic db;
    logic coast;
    logic decel;
    logic zclamp;
    logic [9:0] stop_force;
  } otl_reg_t;

  localparam otl_reg_t RST = '{
    aw_rdy: 1'b1, w_rdy: 1'b1, ar_rdy: 1'b1,
    fwd_cfg: OTL_FWD_USE, rev_cfg: OTL_REV_USE,
    fwd_act: OTL_FWD_USE, rev_act: OTL_REV_USE,
    stop_cfg: OTL_STOP_RST, stop_act: OTL_STOP_RST,
    estop: OTL_ESTOP_RST, warn_cfg: OTL_WARN_RST,
    fwd_allow: 1'b1, rev_allow: 1'b1,
    st: OTL_IDLE, default: '0
  };

  otl_reg_t s_q;
  otl_reg_t s_d;

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  logic fwd_ot_now;
  logic rev_ot_now;
  logic fwd_rise;
  logic rev_rise;
  logic warn_ev;
  logic restart;
  logic do_wr;
  logic [31:0] cur;
  logic [9:0] clamp_force;
  logic [3:0] dig0;
  logic [3:0] dig1;
  logic stop_decel;

  // effective overtravel: an ignored input never trips
  assign fwd_ot_now = (s_q.fwd_act != OTL_IGNORE) && !fwd_limit_in; // RL1 RL5
  assign rev_ot_now = (s_q.rev_act != OTL_IGNORE) && !rev_limit_in; // RL2 RL6
  assign fwd_rise = fwd_ot_now && !s_q.fwd_ot;
  assign rev_rise = rev_ot_now && !s_q.rev_ot;
  assign dig0 = s_q.stop_act[3:0];
  assign dig1 = s_q.stop_act[7:4];
  // force control cannot decelerate, so it falls back on the low digit
  assign stop_decel = (dig1 != 4'h0) && !force_mode_in; // RL8 RL9
  assign clamp_force = (s_q.estop > max_force_in) ? max_force_in : s_q.estop; // RL12

  // warning only on a fresh trip with power already on the cycle before,
  // so power-up over a tripped limit stays silent
  always_comb begin
    warn_ev = 1'b0;
    if (motor_power_in && s_q.pwr_prev && // RL17 RL18
        s_q.warn_cfg[15:12] == OTL_WARN_ON) begin // RL14
      if (ref_active_in) begin
        warn_ev = ref_fwd_in ? fwd_rise : rev_rise; // RL15
      end else begin
        warn_ev = fwd_rise || rev_rise; // RL16
      end
    end
  end

  assign do_wr = s_q.aw_got && s_q.w_got && !s_q.bvalid;
  assign restart = do_wr && s_q.waddr == OTL_CTRL &&
                   s_q.wstrb[0] && s_q.wdata[OTL_CTRL_RESTART];

  // current word at the latched write address, for byte merging
  always_comb begin
    unique case (s_q.waddr)
      OTL_LIMIT_CFG: cur = {24'h0, s_q.rev_cfg, s_q.fwd_cfg};
      OTL_STOP_CFG: cur = {24'h0, s_q.stop_cfg};
      OTL_ESTOP: cur = {22'h0, s_q.estop};
      OTL_WARN_CFG: cur = {16'h0, s_q.warn_cfg};
      default: cur = 32'h0;
    endcase
  end

  // whole next-state computation
  always_comb begin
    logic [31:0] m;
    m = merge(cur, s_q.wdata, s_q.wstrb);
    s_d = s_q;
    // write address and data taken independently, answered when both held
    if (s_axi_awvalid && s_q.aw_rdy) begin
      s_d.aw_rdy = 1'b0;
      s_d.aw_got = 1'b1;
      s_d.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.w_rdy) begin
      s_d.w_rdy = 1'b0;
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (do_wr) begin
      s_d.bvalid = 1'b1;
      s_d.bresp = OTL_OKAY;
      unique case (s_q.waddr)
        OTL_LIMIT_CFG: begin
          s_d.fwd_cfg = m[3:0];
          s_d.rev_cfg = m[7:4];
        end
        OTL_STOP_CFG: s_d.stop_cfg = m[7:0];
        OTL_ESTOP: s_d.estop = m[9:0]; // RL11
        OTL_WARN_CFG: s_d.warn_cfg = m[15:0]; // RL14
        OTL_CTRL: ;
        default: s_d.bresp = OTL_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.aw_rdy = 1'b1;
      s_d.w_rdy = 1'b1;
    end
    // limit and stop settings only bite on a restart
    if (restart) begin
      s_d.fwd_act = s_q.fwd_cfg; // RL5
      s_d.rev_act = s_q.rev_cfg; // RL6
      s_d.stop_act = s_q.stop_cfg; // RL7
    end
    // read channel, one word per address
    if (s_axi_arvalid && s_q.ar_rdy) begin
      s_d.ar_rdy = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = OTL_OKAY;
      s_d.rdata = 32'h0;
      unique case (s_axi_araddr)
        OTL_LIMIT_CFG: s_d.rdata = {24'h0, s_q.rev_cfg, s_q.fwd_cfg};
        OTL_STOP_CFG: s_d.rdata = {24'h0, s_q.stop_cfg};
        OTL_ESTOP: s_d.rdata = {22'h0, s_q.estop};
        OTL_WARN_CFG: s_d.rdata = {16'h0, s_q.warn_cfg};
        OTL_CTRL: ;
        OTL_STATUS: begin
          s_d.rdata[OTL_ST_FWD] = s_q.fwd_ot; // RL21
          s_d.rdata[OTL_ST_REV] = s_q.rev_ot; // RL21
          s_d.rdata[OTL_ST_WARN] = s_q.warn; // RL21
          s_d.rdata[OTL_ST_ERR] = s_q.err_hold;
          if (s_q.warn) begin
            s_d.rdata[OTL_ST_CODE +: 12] = OTL_WARN_CODE;
          end
        end
        default: s_d.rresp = OTL_SLVERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.ar_rdy = 1'b1;
    end
    // limit flags and direction gating
    s_d.fwd_ot = fwd_ot_now; // RL1
    s_d.rev_ot = rev_ot_now; // RL2
    s_d.fwd_allow = !fwd_ot_now; // RL1 RL3
    s_d.rev_allow = !rev_ot_now; // RL2 RL3
    s_d.pwr_prev = motor_power_in;
    // stop sequencer; the warning path never feeds it
    unique case (s_q.st)
      OTL_IDLE: begin
        if ((fwd_rise || rev_rise) && motor_moving_in) begin // RL7
          s_d.st = OTL_STOPPING;
        end
      end
      OTL_STOPPING: begin
        if (motor_stopped_in) begin
          s_d.st = OTL_STOPPED;
        end
      end
      OTL_STOPPED: begin
        // leaves once both limits are clear; moves away from a tripped limit stay allowed
        if (!fwd_ot_now && !rev_ot_now) begin
          s_d.st = OTL_IDLE;
        end
      end
      default: s_d.st = OTL_IDLE;
    endcase
    // held error latch: a new stop wins over a clear in the same cycle
    if (s_d.st == OTL_STOPPING && s_q.st == OTL_IDLE && pos_mode_in) begin
      s_d.err_hold = 1'b1; // RL4
    end else if (error_clear_in) begin
      s_d.err_hold = 1'b0; // RL4
    end
    // stop actions decoded from the next state
    s_d.db = 1'b0;
    s_d.coast = 1'b0;
    s_d.decel = 1'b0;
    s_d.zclamp = 1'b0;
    s_d.stop_force = 10'h0;
    if (s_d.st == OTL_STOPPING) begin
      if (stop_decel) begin
        s_d.decel = 1'b1; // RL8
        s_d.stop_force = clamp_force; // RL11 RL12
      end else if (dig0 == OTL_DIG_COAST) begin
        s_d.coast = 1'b1; // RL8 RL9
      end else begin
        s_d.db = 1'b1; // RL8 RL9
      end
    end else if (s_d.st == OTL_STOPPED) begin
      if (force_mode_in) begin
        s_d.coast = 1'b1; // RL9
      end else if (dig1 == OTL_DIG_ZCLAMP) begin
        s_d.zclamp = 1'b1; // RL10
      end else if (dig1 == OTL_DIG_DCOAST || dig0 != OTL_DIG_DB) begin
        s_d.coast = 1'b1; // RL8
      end else begin
        s_d.db = 1'b1; // RL8
      end
    end
    // warning: set wins, reloads while overtravel lasts, then counts out
    if (warn_ev) begin
      s_d.warn = 1'b1; // RL13
      s_d.warn_cnt = 26'(HOLD_CYC - 1);
    end else if (s_q.warn) begin
      if (fwd_ot_now || rev_ot_now) begin
        s_d.warn_cnt = 26'(HOLD_CYC - 1); // RL19
      end else if (s_q.warn_cnt == 26'h0) begin
        s_d.warn = 1'b0; // RL19
      end else begin
        s_d.warn_cnt = s_q.warn_cnt - 26'h1; // RL19
      end
    end
  end

  // single state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.aw_rdy;
  assign s_axi_wready = s_q.w_rdy;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.ar_rdy;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign fwd_allow_out = s_q.fwd_allow;
  assign rev_allow_out = s_q.rev_allow;
  assign fwd_ot_out = s_q.fwd_ot;
  assign rev_ot_out = s_q.rev_ot;
  assign dynamic_brake_out = s_q.db;
  assign coast_out = s_q.coast;
  assign decel_out = s_q.decel;
  assign zero_clamp_out = s_q.zclamp;
  assign stop_force_out = s_q.stop_force;
  assign hold_error_out = s_q.err_hold;
  // warning drives no stop or gating logic
  assign warning_out = s_q.warn; // RL20

  // checks on the block's own outputs and latched settings
  property p_fwd_ot;
    @(posedge aclk) disable iff (!aresetn)
      (!fwd_limit_in && s_q.fwd_act != OTL_IGNORE) |=> fwd_ot_out && !fwd_allow_out;
  endproperty
  a_fwd_ot: assert property (p_fwd_ot) else $error("forward limit not gated"); // RL1

  property p_rev_ot;
    @(posedge aclk) disable iff (!aresetn)
      (!rev_limit_in && s_q.rev_act != OTL_IGNORE) |=> rev_ot_out && !rev_allow_out;
  endproperty
  a_rev_ot: assert property (p_rev_ot) else $error("reverse limit not gated"); // RL2

  property p_opposite;
    @(posedge aclk) disable iff (!aresetn)
      (!fwd_limit_in && s_q.fwd_act != OTL_IGNORE && rev_limit_in) |=> rev_allow_out;
  endproperty
  a_opposite: assert property (p_opposite) else $error("opposite motion blocked"); // RL3

  property p_err_kept;
    @(posedge aclk) disable iff (!aresetn)
      hold_error_out && !error_clear_in |=> hold_error_out;
  endproperty
  a_err_kept: assert property (p_err_kept) else $error("held error lost"); // RL4

  property p_restart_only;
    @(posedge aclk) disable iff (!aresetn)
      !restart |=> $stable(s_q.fwd_act) && $stable(s_q.stop_act);
  endproperty
  a_restart_only: assert property (p_restart_only) else $error("cfg changed early"); // RL5

  property p_clamp;
    @(posedge aclk) disable iff (!aresetn)
      decel_out |-> stop_force_out <= $past(max_force_in);
  endproperty
  a_clamp: assert property (p_clamp) else $error("stop force over maximum"); // RL12

  property p_force_no_decel;
    @(posedge aclk) disable iff (!aresetn)
      force_mode_in |=> !decel_out && !zero_clamp_out;
  endproperty
  a_force_no_decel: assert property (p_force_no_decel) else $error("decel in force mode"); // RL9

  property p_no_warn_off;
    @(posedge aclk) disable iff (!aresetn)
      !motor_power_in && !warning_out |=> !warning_out;
  endproperty
  a_no_warn_off: assert property (p_no_warn_off) else $error("warning with power off"); // RL17

  property p_warn_held;
    @(posedge aclk) disable iff (!aresetn)
      warning_out && (fwd_ot_out || rev_ot_out) |=> warning_out [*2];
  endproperty
  a_warn_held: assert property (p_warn_held) else $error("warning dropped early"); // RL19

  c_fwd_trip: cover property (@(posedge aclk) disable iff (!aresetn) $rose(fwd_ot_out));
  c_decel: cover property (@(posedge aclk) disable iff (!aresetn) $rose(decel_out));
  c_zclamp: cover property (@(posedge aclk) disable iff (!aresetn) $rose(zero_clamp_out));
  c_warn_end: cover property (@(posedge aclk) disable iff (!aresetn) $fell(warning_out));

endmodule : otl_overtravel

// ===== src/otl_pkg.sv
// overtravel limit block: register map, fields, codes, timing
// assumes a 40 MHz aclk and 32-bit AXI4-Lite register access
package otl_pkg;
  // register byte offsets
  localparam logic [7:0] OTL_LIMIT_CFG = 8'h00;
  localparam logic [7:0] OTL_STOP_CFG = 8'h04;
  localparam logic [7:0] OTL_ESTOP = 8'h08;
  localparam logic [7:0] OTL_WARN_CFG = 8'h0c;
  localparam logic [7:0] OTL_CTRL = 8'h10;
  localparam logic [7:0] OTL_STATUS = 8'h14;
  // reset values and the ignore setting
  localparam logic [3:0] OTL_FWD_USE = 4'h2;
  localparam logic [3:0] OTL_REV_USE = 4'h3;
  localparam logic [3:0] OTL_IGNORE = 4'h8;
  localparam logic [7:0] OTL_STOP_RST = 8'h00;
  localparam logic [9:0] OTL_ESTOP_RST = 10'h320;
  localparam logic [15:0] OTL_WARN_RST = 16'h0000;
  // stop and warning setting digit codes, warning status code
  localparam logic [3:0] OTL_DIG_DB = 4'h0;
  localparam logic [3:0] OTL_DIG_COAST = 4'h2;
  localparam logic [3:0] OTL_DIG_ZCLAMP = 4'h1;
  localparam logic [3:0] OTL_DIG_DCOAST = 4'h2;
  localparam logic [3:0] OTL_WARN_ON = 4'h1;
  localparam logic [11:0] OTL_WARN_CODE = 12'h9a0;
  // status and control bit positions
  localparam int OTL_ST_FWD = 0;
  localparam int OTL_ST_REV = 1;
  localparam int OTL_ST_WARN = 2;
  localparam int OTL_ST_ERR = 3;
  localparam int OTL_ST_CODE = 16;
  localparam int OTL_CTRL_RESTART = 0;
  // axi responses
  localparam logic [1:0] OTL_OKAY = 2'h0;
  localparam logic [1:0] OTL_SLVERR = 2'h2;
  // timing
  localparam longint OTL_CLK_HZ = 40000000;
  localparam longint OTL_HOLD_MS = 1000;
  localparam longint OTL_HOLD_CYC = OTL_CLK_HZ * OTL_HOLD_MS / 1000;
  // stop sequencer, gray along idle -> stopping -> stopped
  typedef enum logic [1:0] {
    OTL_IDLE = 2'b00,
    OTL_STOPPING = 2'b01,
    OTL_STOPPED = 2'b11
  } otl_state_t;
endpackage : otl_pkg

// ===== testbench/otl_far_side.sv
// far side model: two normally closed limit switches, the host clear line and the moving axis
// assumes the bench commands switch openings, clear requests and motion; all on aclk
`timescale 1ns/10ps
module otl_far_side #(
  parameter int STOP_CYC = 8
) (
  input wire logic aclk,
  input wire logic fwd_open,
  input wire logic rev_open,
  input wire logic clear_req,
  input wire logic run,
  input wire logic dynamic_brake_out,
  input wire logic coast_out,
  input wire logic decel_out,
  output logic fwd_limit_in,
  output logic rev_limit_in,
  output logic error_clear_in,
  output logic motor_moving_in,
  output logic motor_stopped_in
);
  int cnt_q = 0;
  // switches start closed so the axis powers up inside its travel range
  initial begin
    fwd_limit_in = 1'b1;
    rev_limit_in = 1'b1;
    error_clear_in = 1'b0;
  end
  // an opened contact reads as off, so a broken wire also stops the axis
  always @(posedge aclk) begin
    fwd_limit_in <= !fwd_open;
    rev_limit_in <= !rev_open;
    error_clear_in <= clear_req;
    if (!run) begin
      cnt_q <= 0;
    end else if ((dynamic_brake_out || coast_out || decel_out) && cnt_q < STOP_CYC) begin
      cnt_q <= cnt_q + 1;
    end
  end
  // the axis needs STOP_CYC cycles of stop action before it reads as standing still
  assign motor_stopped_in = !run || cnt_q == STOP_CYC;
  assign motor_moving_in = !motor_stopped_in;
endmodule : otl_far_side

// ===== testbench/testbench.sv
// self-checking bench: AXI4-Lite master, far side model, queued expectations
// assumes the design package and a shortened warning hold of 20 cycles
`timescale 1ns/10ps
module testbench import otl_pkg::*;;
  localparam int HOLD = 20;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic fwd_open = 0, rev_open = 0, clear_req = 0, run = 0, snap = 0;
  logic power = 1, pos_mode = 0, force_mode = 0, ref_act = 0, ref_fwd = 0;
  logic [9:0] maxf = 10'h3ff, est, force_x;
  logic fl, rl, ec, mv, ms, fa, ra, fo, ro, db, co, de, zc, he, wn;
  logic [9:0] sf;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [39:0] pq[$];
  int fails = 0, tests_run = 0;
  logic [7:0] codes[6] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h20, 8'h10};
  logic [3:0] stp[6] = '{4'b1000, 4'b1000, 4'b0100, 4'b0010, 4'b0010, 4'b1000};
  logic [3:0] aft[6] = '{4'b1000, 4'b0100, 4'b0100, 4'b0001, 4'b0100, 4'b0100};
  logic [31:0] rst_val[6] = '{32'h32, 32'h0, 32'h320, 32'h0, 32'h0, 32'h0};

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  otl_overtravel #(.HOLD_CYC(HOLD)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fwd_limit_in(fl), .rev_limit_in(rl), .error_clear_in(ec), .motor_power_in(power),
    .pos_mode_in(pos_mode), .force_mode_in(force_mode), .ref_active_in(ref_act),
    .ref_fwd_in(ref_fwd), .motor_moving_in(mv), .motor_stopped_in(ms), .max_force_in(maxf),
    .fwd_allow_out(fa), .rev_allow_out(ra), .fwd_ot_out(fo), .rev_ot_out(ro),
    .dynamic_brake_out(db), .coast_out(co), .decel_out(de), .zero_clamp_out(zc),
    .stop_force_out(sf), .hold_error_out(he), .warning_out(wn));

  otl_far_side #(.STOP_CYC(8)) far (.aclk(aclk), .fwd_open(fwd_open), .rev_open(rev_open),
    .clear_req(clear_req), .run(run), .dynamic_brake_out(db), .coast_out(co),
    .decel_out(de), .fwd_limit_in(fl), .rev_limit_in(rl), .error_clear_in(ec),
    .motor_moving_in(mv), .motor_stopped_in(ms));

  task automatic cmp(input string what, input logic [33:0] e, input logic [33:0] s);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask : cmp

  // watcher: every result that shows up retires the oldest note of its kind
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready) cmp("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
    if (rvalid === 1'b1 && rready) cmp("rdata", rq.pop_front(), {rresp, rdata});
    if (snap) begin
      logic [39:0] n;
      n = pq.pop_front();
      cmp("ports", {14'h0, n[19:0]},
          {14'h0, n[39:20] & {sf, fa, ra, fo, ro, db, co, de, zc, he, wn}});
    end
  end

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin do @(posedge aclk); while (awready !== 1'b1); awvalid <= 1'b0; end
      begin do @(posedge aclk); while (wready !== 1'b1); wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    @(posedge aclk); // spacing so the next request never lands in the release step
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    rq.push_back({er, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axr

  // note the expected port image, then strobe the watcher for one edge
  task automatic chk(input logic [19:0] m, input logic [19:0] e);
    pq.push_back({m, e});
    snap <= 1'b1;
    @(posedge aclk);
    snap <= 1'b0;
    @(posedge aclk);
  endtask : chk

  task automatic trip(input logic f, input logic r, input int n, input logic w);
    fwd_open <= f;
    rev_open <= r;
    repeat (n) @(posedge aclk);
    chk(20'h00001, {19'h0, w});
  endtask : trip

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    #(25ns * 20000);
    fails++;
    report_and_stop();
  end

  initial begin
    logic [31:0] r;
    void'($urandom(32'he58146eb));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) axr(8'(i * 4), rst_val[i], OTL_OKAY);
    axr(8'h1c, 32'h0, OTL_SLVERR);
    axw(8'h1c, $urandom, OTL_SLVERR);
    $display("test registers done");
    // pass 0 default, pass 1 ignore written but pending, pass 2 after restart
    for (int p = 0; p < 3; p++) begin
      if (p == 1) axw(OTL_LIMIT_CFG, 32'h88, OTL_OKAY);
      if (p == 2) axw(OTL_CTRL, 32'h1, OTL_OKAY);
      for (int k = 0; k < 8; k++) begin
        r = $urandom;
        fwd_open <= r[0];
        rev_open <= r[1];
        repeat (3) @(posedge aclk);
        if (p < 2) chk(20'h003c0, {10'h0, !r[0], !r[1], r[0], r[1], 6'h0});
        else chk(20'h003c0, {10'h0, 4'b1100, 6'h0});
      end
    end
    fwd_open <= 1'b0;
    rev_open <= 1'b0;
    axw(OTL_LIMIT_CFG, 32'h32, OTL_OKAY);
    axw(OTL_CTRL, 32'h1, OTL_OKAY);
    $display("test limits done");
    maxf <= 10'(100 + $urandom % 600);
    for (int i = 0; i < 6; i++) begin
      est = (i == 4) ? 10'h064 : 10'h320;
      axw(OTL_STOP_CFG, {24'h0, codes[i]}, OTL_OKAY);
      axw(OTL_ESTOP, {22'h0, est}, OTL_OKAY);
      axw(OTL_CTRL, 32'h1, OTL_OKAY);
      force_mode <= (i == 5);
      pos_mode <= (i == 0);
      run <= 1'b1;
      repeat (3) @(posedge aclk);
      fwd_open <= 1'b1;
      repeat (3) @(posedge aclk);
      force_x = stp[i][1] ? ((est < maxf) ? est : maxf) : 10'h0;
      chk(20'hffffe, {force_x, 4'b0110, stp[i], i == 0, 1'b0});
      repeat (14) @(posedge aclk);
      chk(20'hffffe, {10'h0, 4'b0110, aft[i], i == 0, 1'b0});
      if (i == 0) begin
        clear_req <= 1'b1;
        repeat (3) @(posedge aclk);
        clear_req <= 1'b0;
        chk(20'h00002, 20'h0);
      end
      fwd_open <= 1'b0;
      run <= 1'b0;
      repeat (6) @(posedge aclk);
    end
    force_mode <= 1'b0;
    pos_mode <= 1'b0;
    $display("test stopping done");
    trip(1, 0, 4, 0);
    trip(0, 0, 30, 0);
    axw(OTL_WARN_CFG, 32'h1000, OTL_OKAY);
    trip(0, 1, 4, 1);
    axr(OTL_STATUS, 32'h09a0_0006, OTL_OKAY);
    trip(0, 0, 12, 1);
    trip(0, 0, 18, 0);
    ref_act <= 1'b1;
    ref_fwd <= 1'b1;
    trip(0, 1, 4, 0);
    trip(1, 1, 4, 1);
    chk(20'h00300, 20'h00000);
    trip(0, 0, 40, 0);
    ref_act <= 1'b0;
    power <= 1'b0;
    trip(1, 0, 4, 0);
    power <= 1'b1;
    trip(1, 0, 6, 0);
    trip(0, 0, 40, 0);
    fwd_open <= 1'b1;
    @(posedge aclk);
    fwd_open <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(20'h00001, 20'h00001);
    $display("test warning done");
    repeat (4) @(posedge aclk);
    report_and_stop();
  end
endmodule : testbench
